/* File: common/usu_pkg.sv */
// Purpose: constants, types and helpers for the serial bridge core
// Assumes: 10 MHz ref_clk, apb register access, 32-bit data
// Notes: operation of the core in brief
// Operation
// - baud generator makes a 16x oversampling tick from 48 MHz reference, 14+3 bits
// - bit rate equals 3000000 divided by integer plus fractional divisor
// - integer divisor ranges 2 to 16384, fraction in eighths 0 to 0.875
// - divisor one with zero fraction allowed; divisors between one and two never produced
// - characters of seven or eight data bits are sent and received
// - host bytes queue in a 128-byte transmit fifo feeding the transmitter
// - received characters queue in a 256-byte receive fifo until host reads
// - modem lines rts, cts, dsr, dtr, dcd and ri are provided
// - rts/cts, dtr/dsr or xon/xoff flow control selectable, done in hardware
// - break can be forced on transmit line and is detected on receive
// - every uart line has its own polarity inversion bit
// - rs485_driver_enable is asserted while the transmitter is sending
// - five control bus pins, each with one function picked by configuration
// - tx, rx and traffic led outputs pulse low on data activity
// - suspend_indicator_n shows that the device is in usb suspend
// - a control bus pin can output a 48, 24, 12 or 6 MHz clock
// - clock outputs stop toggling during usb suspend
// - up to four control bus pins serve as gpio alongside the uart
// - async bit-bang turns the eight uart lines into one 8-bit port
// - async bit-bang applies host bytes in turn, paced by the baud timer
// - bit-bang modes pulse read_strobe_n and write_strobe_n on port accesses
// - sync bit-bang samples the port only when a byte is written
// - power_enable_n low once configured, high again during usb suspend
package usu_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_DATA = 8'h00;
	localparam logic [7:0] OFF_BAUD = 8'h04;
	localparam logic [7:0] OFF_LINE = 8'h08;
	localparam logic [7:0] OFF_MODEM = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_INVERT = 8'h14;
	localparam logic [7:0] OFF_CONTROL_BUS_PINS = 8'h18;
	localparam logic [7:0] OFF_BITBANG = 8'h1c;
	localparam logic [7:0] OFF_GPIO = 8'h20;
	localparam logic [7:0] OFF_USB = 8'h24;
	localparam int TX_FIFO_BYTES = 128;
	localparam int RX_FIFO_BYTES = 256;
	localparam int RX_ROOM_BYTES = 32;
	// baud arithmetic: divisor in eighths, scaled so 48/10 MHz is an integer step
	localparam int REF_MHZ = 48;
	localparam int CLK_MHZ = 10;
	localparam int DIV_SCALE = 10;
	localparam int BAUD_STEP = REF_MHZ * 8 * DIV_SCALE / CLK_MHZ;
	localparam logic [17:0] DIV_MAX_E8 = 18'h20000;
	localparam logic [17:0] DIV_ONE_E8 = 18'h00008;
	localparam logic [13:0] BAUD_N_RST = 14'h001a;
	localparam int LED_PULSE_MS = 50;
	localparam int LED_PULSE_CYC = LED_PULSE_MS * CLK_MHZ * 1000;
	localparam logic [19:0] CONTROL_BUS_PINS_SEL_RST = 20'h51032;
	localparam logic [7:0] UART_OE_N = 8'hea;
	localparam logic [7:0] XON_CHAR = 8'h11;
	localparam logic [7:0] XOFF_CHAR = 8'h13;
	// status bit positions
	localparam int ST_BRK = 9;
	localparam int ST_ERR = 10;
	localparam int ST_OVF = 11;
	localparam logic [1:0] FLOW_NONE = 2'h0;
	localparam logic [1:0] FLOW_RTSCTS = 2'h1;
	localparam logic [1:0] FLOW_DTRDSR = 2'h2;
	localparam logic [1:0] FLOW_XON = 2'h3;
	localparam logic [2:0] PAR_NONE = 3'h0;
	localparam logic [2:0] PAR_ODD = 3'h1;
	localparam logic [2:0] PAR_EVEN = 3'h2;
	localparam logic [2:0] PAR_MARK = 3'h3;
	localparam logic [1:0] BB_OFF = 2'h0;
	localparam logic [1:0] BB_ASYNC = 2'h1;
	localparam logic [1:0] BB_SYNC = 2'h2;
	typedef enum logic [3:0] {
		CB_RS485_DRIVER_ENABLE = 4'h0, CB_POWER_ENABLE_N = 4'h1, CB_TX_ACTIVITY_LED_N = 4'h2, CB_RX_ACTIVITY_LED_N = 4'h3,
		CB_TRAFFIC = 4'h4, CB_SLEEP = 4'h5, CB_CLOCK_OUT_48MHZ = 4'h6, CB_CLOCK_OUT_24MHZ = 4'h7,
		CB_CLOCK_OUT_12MHZ = 4'h8, CB_CLOCK_OUT_6MHZ = 4'h9, CB_GPIO = 4'ha, CB_WRSTB = 4'hb, CB_RDSTB = 4'hc
	} usu_control_bus_pins_t;
	typedef enum logic [4:0] {
		F_IDLE = 5'b00001, F_START = 5'b00010, F_DATA = 5'b00100,
		F_PAR = 5'b01000, F_STOP = 5'b10000
	} usu_frame_t;
	typedef struct packed {
		logic [1:0] flow;
		logic brk;
		logic stop2;
		logic [2:0] parity;
		logic data7;
	} usu_line_t;
	function automatic logic usu_parity(input logic [2:0] code, input logic x);
		case (code)
			PAR_ODD: usu_parity = ~x;
			PAR_EVEN: usu_parity = x;
			PAR_MARK: usu_parity = 1'b1;
			default: usu_parity = 1'b0;
		endcase
	endfunction
endpackage

/* File: hdl/usu_uart_core.sv */
// Purpose: serial core of a usb-to-serial bridge behind an apb slave
// Assumes: fifo depths are powers of two; apb answers with one wait state
// Notes: ref_clk is far below 48 MHz, so clocks and baud ticks are scaled
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module usu_uart_core import usu_pkg::*; #(
	parameter int TX_DEPTH = TX_FIFO_BYTES,
	parameter int RX_DEPTH = RX_FIFO_BYTES,
	parameter int RX_MARGIN = RX_ROOM_BYTES,
	parameter int LED_PULSE = LED_PULSE_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// uart lines / bit-bang port: 0 txd 1 rxd 2 rts 3 cts 4 dtr 5 dsr 6 dcd 7 ri
	input wire logic [7:0] port_in,
	output logic [7:0] port_out,
	output logic [7:0] port_oe_n,
	// control bus pins
	input wire logic [4:0] control_bus_pins_in,
	output logic [4:0] control_bus_pins,
	output logic [4:0] control_bus_oe_n
);
	localparam int TXA_W = $clog2(TX_DEPTH);
	localparam int RXA_W = $clog2(RX_DEPTH);
	localparam int TXC_W = TXA_W + 1;
	localparam int RXC_W = RXA_W + 1;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);

	// ----------------------------------------------------------------
	// registers and apb
	// ----------------------------------------------------------------
	logic [13:0] div_n;
	logic [2:0] div_f;
	usu_line_t line;
	logic [1:0] modem;
	logic [7:0] inv;
	logic [19:0] control_bus_pins_sel;
	logic [1:0] bb_mode;
	logic [7:0] bb_dir;
	logic [3:0] gpio_out, gpio_dir;
	logic usb_cfg, usb_susp;
	logic brk_seen, line_err, tx_ovf, xoff_hold;
	logic [12:0] sy1, sy2, sy3, pin_f;
	logic [TXA_W-1:0] tx_wr, tx_rd;
	logic [RXA_W-1:0] rx_wr, rx_rd;
	logic [TXC_W-1:0] tx_cnt;
	logic [RXC_W-1:0] rx_cnt;
	logic [7:0] tx_mem [TX_DEPTH];
	logic [7:0] rx_mem [RX_DEPTH];
	logic [31:0] rd_val;
	logic addr_ok, apb_done, apb_wr;
	logic [7:0] in_l;
	logic rxd, cts_ok, dsr_ok, dcd_on, ri_on;
	logic tx_full, rx_full, tx_push, rx_pop, rx_push, rx_push_u, tx_pop, rx_room;

	assign apb_done = psel & penable & pready;
	assign apb_wr = apb_done & pwrite & addr_ok;
	assign addr_ok = (paddr <= OFF_USB) && (paddr[1:0] == 2'b00);
	assign tx_full = tx_cnt == TXC_W'(TX_DEPTH);
	assign rx_full = rx_cnt == RXC_W'(RX_DEPTH);
	assign tx_push = apb_wr & (paddr == OFF_DATA);
	assign rx_pop = apb_done & ~pwrite & (paddr == OFF_DATA) & (rx_cnt != '0);

	always_comb begin
		rd_val = 32'h0;
		case (paddr)
			OFF_DATA: rd_val[7:0] = rx_mem[rx_rd];
			OFF_BAUD: rd_val[16:0] = {div_f, div_n};
			OFF_LINE: rd_val[7:0] = line;
			OFF_MODEM: rd_val[1:0] = modem;
			OFF_STATUS: rd_val[11:0] = {tx_ovf, line_err, brk_seen, xoff_hold,
				ri_on, dcd_on, dsr_ok, cts_ok, rx_cnt == '0, rx_full, tx_cnt == '0, tx_full};
			OFF_INVERT: rd_val[7:0] = inv;
			OFF_CONTROL_BUS_PINS: rd_val[19:0] = control_bus_pins_sel;
			OFF_BITBANG: rd_val[15:0] = {bb_dir, 6'h00, bb_mode};
			OFF_GPIO: rd_val[11:0] = {pin_f[11:8], gpio_dir, gpio_out};
			OFF_USB: rd_val[1:0] = {usb_susp, usb_cfg};
			default: rd_val = 32'h0;
		endcase
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addr_ok;
			prdata <= (psel & penable & ~pready & ~pwrite) ? rd_val : 32'h0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			div_n <= BAUD_N_RST;
			div_f <= 3'h0;
			line <= '0;
			modem <= 2'h0;
			inv <= 8'h00;
			control_bus_pins_sel <= CONTROL_BUS_PINS_SEL_RST;
			bb_mode <= BB_OFF;
			bb_dir <= 8'h00;
			gpio_out <= 4'h0;
			gpio_dir <= 4'h0;
			usb_cfg <= 1'b0;
			usb_susp <= 1'b0;
		end else if (apb_wr) begin
			case (paddr)
				OFF_BAUD: {div_f, div_n} <= pwdata[16:0];
				OFF_LINE: line <= pwdata[7:0];
				OFF_MODEM: modem <= pwdata[1:0];
				OFF_INVERT: inv <= pwdata[7:0];
				OFF_CONTROL_BUS_PINS: control_bus_pins_sel <= pwdata[19:0];
				OFF_BITBANG: {bb_dir, bb_mode} <= {pwdata[15:8], pwdata[1:0]};
				OFF_GPIO: {gpio_dir, gpio_out} <= pwdata[7:0];
				OFF_USB: {usb_susp, usb_cfg} <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pin input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sy1 <= 13'h1fff;
			sy2 <= 13'h1fff;
			sy3 <= 13'h1fff;
			pin_f <= 13'h1fff;
		end else begin
			sy1 <= {control_bus_pins_in, port_in};
			sy2 <= sy1;
			sy3 <= sy2;
			pin_f <= (sy2 & sy3) | (pin_f & (sy2 ^ sy3));
		end
	end

	// modem lines idle high at the pin and are active low
	assign in_l = pin_f[7:0] ^ inv;
	assign rxd = in_l[1];
	assign cts_ok = ~in_l[3];
	assign dsr_ok = ~in_l[5];
	assign dcd_on = ~in_l[6];
	assign ri_on = ~in_l[7];

	// ----------------------------------------------------------------
	// baud generator
	// ----------------------------------------------------------------
	logic [17:0] div_e8;
	logic [21:0] d10, acc, acc_sum;
	logic tick16, pace;
	logic [3:0] pace_cnt;

	always_comb begin
		if (div_n == 14'h0) begin
			div_e8 = DIV_MAX_E8;
		end else if (div_n == 14'h1) begin
			div_e8 = DIV_ONE_E8;
		end else begin
			div_e8 = {1'b0, div_n, div_f};
		end
	end
	assign d10 = {4'h0, div_e8} * 22'(DIV_SCALE);
	assign acc_sum = acc + 22'(BAUD_STEP);

	// 16x tick = 48 MHz / divisor, so bit rate = 3 MHz / divisor; limited to ref_clk
	always_ff @(posedge ref_clk) begin
		if (srst || (apb_wr && paddr == OFF_BAUD)) begin
			acc <= 22'h0;
			tick16 <= 1'b0;
		end else if (acc_sum >= d10) begin
			acc <= acc_sum - d10;
			tick16 <= 1'b1;
		end else begin
			acc <= acc_sum;
			tick16 <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pace_cnt <= 4'h0;
		end else if (tick16) begin
			pace_cnt <= pace_cnt + 4'h1;
		end
	end
	assign pace = tick16 & (pace_cnt == 4'hf);

	// ----------------------------------------------------------------
	// fifos
	// ----------------------------------------------------------------
	logic tx_push_ok, rx_push_ok;
	logic [7:0] rx_din, rx_byte, tx_head;
	logic bb_act, bb_pop, bb_sample;
	assign tx_push_ok = tx_push & ~tx_full;
	assign rx_push_ok = rx_push & ~rx_full;
	assign tx_head = tx_mem[tx_rd];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_wr <= '0;
			tx_rd <= '0;
			tx_cnt <= '0;
		end else begin
			if (tx_push_ok) begin
				tx_mem[tx_wr] <= pwdata[7:0];
				tx_wr <= tx_wr + TXA_W'(1);
			end
			if (tx_pop) begin
				tx_rd <= tx_rd + TXA_W'(1);
			end
			tx_cnt <= tx_cnt + TXC_W'(tx_push_ok) - TXC_W'(tx_pop);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rx_wr <= '0;
			rx_rd <= '0;
			rx_cnt <= '0;
		end else begin
			if (rx_push_ok) begin
				rx_mem[rx_wr] <= rx_din;
				rx_wr <= rx_wr + RXA_W'(1);
			end
			if (rx_pop) begin
				rx_rd <= rx_rd + RXA_W'(1);
			end
			rx_cnt <= rx_cnt + RXC_W'(rx_push_ok) - RXC_W'(rx_pop);
		end
	end
	assign rx_room = rx_cnt < RXC_W'(RX_DEPTH - RX_MARGIN);

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	usu_frame_t tx_st, rx_st;
	logic [3:0] tx_sub, rx_sub;
	logic [2:0] tx_bit, rx_bit, last_bit;
	logic [7:0] tx_sh, rx_sh;
	logic tx_line, tx_par, tx_stops, tx_busy, flow_ok, tx_go, tx_end;
	assign last_bit = line.data7 ? 3'd6 : 3'd7;
	assign tx_end = tick16 & (tx_sub == 4'hf);

	always_comb begin
		case (line.flow)
			FLOW_RTSCTS: flow_ok = cts_ok;
			FLOW_DTRDSR: flow_ok = dsr_ok;
			FLOW_XON: flow_ok = ~xoff_hold;
			default: flow_ok = 1'b1;
		endcase
	end
	assign tx_go = ~bb_act & (tx_cnt != '0) & flow_ok & ~line.brk;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_st <= F_IDLE;
			tx_sub <= 4'h0;
			tx_bit <= 3'h0;
			tx_sh <= 8'h00;
			tx_line <= 1'b1;
			tx_par <= 1'b0;
			tx_stops <= 1'b0;
		end else begin
			if (tx_st != F_IDLE && tick16) begin
				tx_sub <= tx_sub + 4'h1;
			end
			case (tx_st)
				F_IDLE: if (tx_go) begin
					tx_sh <= tx_head;
					tx_par <= usu_parity(line.parity, line.data7 ? ^tx_head[6:0] : ^tx_head);
					tx_line <= 1'b0;
					tx_sub <= 4'h0;
					tx_st <= F_START;
				end
				F_START: if (tx_end) begin
					tx_line <= tx_sh[0];
					tx_bit <= 3'h0;
					tx_st <= F_DATA;
				end
				F_DATA: if (tx_end) begin
					if (tx_bit != last_bit) begin
						tx_bit <= tx_bit + 3'h1;
						tx_sh <= tx_sh >> 1;
						tx_line <= tx_sh[1];
					end else if (line.parity != PAR_NONE) begin
						tx_line <= tx_par;
						tx_st <= F_PAR;
					end else begin
						tx_line <= 1'b1;
						tx_stops <= line.stop2;
						tx_st <= F_STOP;
					end
				end
				F_PAR: if (tx_end) begin
					tx_line <= 1'b1;
					tx_stops <= line.stop2;
					tx_st <= F_STOP;
				end
				F_STOP: if (tx_end) begin
					if (tx_stops) begin
						tx_stops <= 1'b0;
					end else begin
						tx_st <= F_IDLE;
					end
				end
				default: tx_st <= F_IDLE;
			endcase
		end
	end
	assign tx_pop = (tx_st == F_IDLE && tx_go) | bb_pop;

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	logic rx_zero, rx_perr, rx_hold, rx_end, rx_ctrl, rx_brk;
	assign rx_end = tick16 & (rx_sub == 4'hf);
	assign rx_byte = line.data7 ? {1'b0, rx_sh[7:1]} : rx_sh;
	assign rx_ctrl = (line.flow == FLOW_XON) && (rx_byte == XON_CHAR || rx_byte == XOFF_CHAR);
	assign rx_brk = (rx_st == F_STOP) & rx_end & ~rxd & rx_zero;
	assign rx_push_u = (rx_st == F_STOP) & rx_end & ~rx_brk & ~rx_ctrl;
	assign rx_push = (rx_push_u & ~bb_act) | bb_sample;
	assign rx_din = bb_sample ? pin_f[7:0] : rx_byte;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rx_st <= F_IDLE;
			rx_sub <= 4'h0;
			rx_bit <= 3'h0;
			rx_sh <= 8'h00;
			rx_zero <= 1'b0;
			rx_perr <= 1'b0;
			rx_hold <= 1'b0;
		end else begin
			if (rx_st != F_IDLE && tick16) begin
				rx_sub <= rx_sub + 4'h1;
			end
			if (rxd) begin
				rx_hold <= 1'b0;
			end
			case (rx_st)
				F_IDLE: if (tick16 && !rxd && !rx_hold && !bb_act) begin
					rx_sub <= 4'h0;
					rx_st <= F_START;
				end
				F_START: if (tick16 && rx_sub == 4'h7) begin
					rx_sub <= 4'h0;
					rx_bit <= 3'h0;
					rx_zero <= 1'b1;
					rx_perr <= 1'b0;
					rx_st <= rxd ? F_IDLE : F_DATA;
				end
				F_DATA: if (rx_end) begin
					rx_sh <= {rxd, rx_sh[7:1]};
					rx_zero <= rx_zero & ~rxd;
					rx_bit <= rx_bit + 3'h1;
					if (rx_bit == last_bit) begin
						rx_st <= (line.parity != PAR_NONE) ? F_PAR : F_STOP;
					end
				end
				F_PAR: if (rx_end) begin
					rx_perr <= rxd != usu_parity(line.parity, ^rx_byte);
					rx_zero <= rx_zero & ~rxd;
					rx_st <= F_STOP;
				end
				F_STOP: if (rx_end) begin
					rx_hold <= rx_brk; // wait for idle before hunting again
					rx_st <= F_IDLE;
				end
				default: rx_st <= F_IDLE;
			endcase
		end
	end

	// sticky flags: a new event wins over a software clear in the same cycle
	logic clr_st;
	assign clr_st = apb_wr & (paddr == OFF_STATUS);
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			brk_seen <= 1'b0;
			line_err <= 1'b0;
			tx_ovf <= 1'b0;
			xoff_hold <= 1'b0;
		end else begin
			brk_seen <= rx_brk | (brk_seen & ~(clr_st & pwdata[ST_BRK]));
			line_err <= (rx_push_u & (~rxd | rx_perr)) | (line_err & ~(clr_st & pwdata[ST_ERR]));
			tx_ovf <= (tx_push & tx_full) | (tx_ovf & ~(clr_st & pwdata[ST_OVF]));
			if (line.flow != FLOW_XON) begin
				xoff_hold <= 1'b0;
			end else if (rx_st == F_STOP && rx_end && rx_ctrl) begin
				xoff_hold <= rx_byte == XOFF_CHAR;
			end
		end
	end

	// ----------------------------------------------------------------
	// bit-bang port
	// ----------------------------------------------------------------
	logic [7:0] bb_out;
	logic wr_strobe_n, rd_strobe_n;
	assign bb_act = bb_mode == BB_ASYNC || bb_mode == BB_SYNC;
	assign bb_pop = bb_act & pace & (tx_cnt != '0);
	assign bb_sample = bb_act & pace & ((bb_mode == BB_ASYNC) | (tx_cnt != '0));

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bb_out <= 8'hff;
			wr_strobe_n <= 1'b1;
			rd_strobe_n <= 1'b1;
		end else begin
			if (bb_pop) begin
				bb_out <= tx_head;
			end
			wr_strobe_n <= ~bb_pop;
			rd_strobe_n <= ~bb_sample;
		end
	end

	// ----------------------------------------------------------------
	// status outputs, leds, clocks
	// ----------------------------------------------------------------
	logic [19:0] txl_cnt, rxl_cnt;
	logic [3:0] clk_div;
	logic power_enable_n, suspend_indicator_n, rs485_driver_enable;
	logic rts_on, dtr_on;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			txl_cnt <= 20'h0;
			rxl_cnt <= 20'h0;
			clk_div <= 4'h0;
			tx_busy <= 1'b0;
			power_enable_n <= 1'b1;
			suspend_indicator_n <= 1'b1;
		end else begin
			txl_cnt <= tx_pop ? 20'(LED_PULSE) : txl_cnt - 20'(txl_cnt != 20'h0);
			rxl_cnt <= rx_push_ok ? 20'(LED_PULSE) : rxl_cnt - 20'(rxl_cnt != 20'h0);
			if (!usb_susp) begin
				clk_div <= clk_div + 4'h1;
			end
			tx_busy <= tx_st != F_IDLE;
			power_enable_n <= ~(usb_cfg & ~usb_susp);
			suspend_indicator_n <= ~usb_susp;
		end
	end
	assign rs485_driver_enable = tx_busy;
	assign rts_on = modem[0] & (line.flow != FLOW_RTSCTS | rx_room);
	assign dtr_on = modem[1] & (line.flow != FLOW_DTRDSR | rx_room);

	logic [4:0] cb_o, cb_oe_n;
	logic [7:0] uart_o;
	logic tx_activity_led_n, rx_activity_led_n, traffic_led_n;
	assign tx_activity_led_n = txl_cnt == 20'h0;
	assign rx_activity_led_n = rxl_cnt == 20'h0;
	assign traffic_led_n = tx_activity_led_n & rx_activity_led_n;

	always_comb begin
		for (int i = 0; i < 5; i++) begin
			cb_oe_n[i] = 1'b0;
			case (usu_control_bus_pins_t'(control_bus_pins_sel[i*4 +: 4]))
				CB_RS485_DRIVER_ENABLE: cb_o[i] = rs485_driver_enable;
				CB_POWER_ENABLE_N: cb_o[i] = power_enable_n;
				CB_TX_ACTIVITY_LED_N: cb_o[i] = tx_activity_led_n;
				CB_RX_ACTIVITY_LED_N: cb_o[i] = rx_activity_led_n;
				CB_TRAFFIC: cb_o[i] = traffic_led_n;
				CB_SLEEP: cb_o[i] = suspend_indicator_n;
				CB_CLOCK_OUT_48MHZ: cb_o[i] = clk_div[0];
				CB_CLOCK_OUT_24MHZ: cb_o[i] = clk_div[1];
				CB_CLOCK_OUT_12MHZ: cb_o[i] = clk_div[2];
				CB_CLOCK_OUT_6MHZ: cb_o[i] = clk_div[3];
				CB_WRSTB: cb_o[i] = wr_strobe_n;
				CB_RDSTB: cb_o[i] = rd_strobe_n;
				CB_GPIO: begin
					cb_o[i] = (i < 4) ? gpio_out[i%4] : 1'b1;
					cb_oe_n[i] = (i < 4) ? ~gpio_dir[i%4] : 1'b1;
				end
				default: begin
					cb_o[i] = 1'b1;
					cb_oe_n[i] = 1'b1;
				end
			endcase
		end
	end

	always_comb begin
		uart_o = 8'hff;
		uart_o[0] = tx_line & ~line.brk;
		uart_o[2] = ~rts_on;
		uart_o[4] = ~dtr_on;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			port_out <= 8'hff;
			port_oe_n <= 8'hff;
			control_bus_pins <= 5'h1f;
			control_bus_oe_n <= 5'h1f;
		end else begin
			port_out <= bb_act ? bb_out : uart_o ^ inv;
			port_oe_n <= bb_act ? ~bb_dir : UART_OE_N;
			control_bus_pins <= cb_o;
			control_bus_oe_n <= cb_oe_n;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_tx_event;
		tx_pop;
	endsequence
	sequence s_led_lit;
		(txl_cnt != 20'h0) ##1 !tx_activity_led_n;
	endsequence

	chk_div_no_gap: assert property (div_e8 == DIV_ONE_E8 || div_e8 >= 18'h10)
		else $error("divisor between one and two");
	chk_div_range: assert property ((div_n >= 14'h2) |-> div_e8 == {1'b0, div_n, div_f})
		else $error("divisor not taken from register");
	chk_baud_acc: assert property ((d10 > 22'(BAUD_STEP)) |-> acc < d10)
		else $error("baud accumulator out of range");
	chk_rs485_driver_enable_busy: assert property ((tx_st != F_IDLE) |=> rs485_driver_enable)
		else $error("driver enable low while sending");
	chk_tx_bound: assert property (tx_cnt <= TXC_W'(TX_DEPTH))
		else $error("transmit fifo count overflow");
	chk_rx_count: assert property ((rx_push_ok && !rx_pop) |=> rx_cnt == $past(rx_cnt) + RXC_W'(1))
		else $error("receive fifo count did not grow");
	chk_break_line: assert property ((line.brk && !bb_act) |=> port_out[0] == $past(inv[0]))
		else $error("break not forced on transmit pin");
	chk_cts_hold: assert property ((tx_st == F_IDLE && !bb_act && line.flow == FLOW_RTSCTS && !cts_ok) |=> tx_st == F_IDLE)
		else $error("sent while cts deasserted");
	chk_led_pulse: assert property (s_tx_event |=> s_led_lit)
		else $error("led pulse missing after activity");
	chk_clk_stop: assert property (usb_susp |=> $stable(clk_div))
		else $error("clock output toggles in suspend");
	chk_sync_sample: assert property ((bb_mode == BB_SYNC && bb_sample) |-> bb_pop)
		else $error("sync sample without output byte");
	chk_pwr_suspend: assert property (usb_susp |=> power_enable_n)
		else $error("power enable low in suspend");
endmodule

/* File: sim/usu_line_model.sv */
// Purpose: far-side serial device wired to the core's uart pins
// Assumes: same rate, width, parity and stop bits as the core
// Notes: released pins show the bench's changing pattern, not a held value
`timescale 1ns/100ps
module usu_line_model (
	// pins of the core
	input wire logic [7:0] port_out,
	input wire logic [7:0] port_oe_n,
	// far side
	input wire logic loop,
	input wire logic [7:0] ext,
	output logic [7:0] port_in
);
	logic [7:0] w;
	assign w = (port_out & ~port_oe_n) | (ext & port_oe_n);
	// txd echoes to rxd, rts to cts, dtr to dsr
	assign port_in = loop ? {w[7:6], w[4], w[4], w[2], w[2], w[0], w[0]} : w;
endmodule

/* File: sim/usu_uart_core_tb_top.sv */
// Purpose: self-checking bench of the serial core over apb
// Assumes: loopback partner, led pulse shortened to 8 cycles
// Notes: random bytes from an xorshift seeded at 59
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module usu_uart_core_tb_top import usu_pkg::*;;
	logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, loop = 1;
	logic [7:0] paddr = 0, port_in, port_out, port_oe_n, ext = 0, b [3];
	logic [31:0] pwdata = 0, prdata, q, seed = 59;
	logic [4:0] control_bus_pins_in = 0, control_bus_pins, control_bus_oe_n;
	int bad_count = 0, cmp_count = 0;
	usu_uart_core #(.LED_PULSE(8)) i_usu_uart_core (.ref_clk(ref_clk), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .port_in(port_in),
		.port_out(port_out), .port_oe_n(port_oe_n), .control_bus_pins_in(control_bus_pins_in),
		.control_bus_pins(control_bus_pins), .control_bus_oe_n(control_bus_oe_n));
	usu_line_model i_usu_line_model (.port_out(port_out), .port_oe_n(port_oe_n),
		.loop(loop), .ext(ext), .port_in(port_in));
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] exp_char(input logic [7:0] c, input logic s7);
		return s7 ? {25'h0, c[6:0]} : {24'h0, c};
	endfunction
	always @(posedge ref_clk) begin
		ext <= 8'(xs());
		control_bus_pins_in <= 5'(xs());
	end
	// waits for pready without a limit of its own: only the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = pslverr ? 32'hdead : prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge ref_clk);
		bad_count++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		srst <= 0;
		repeat (3) @(posedge ref_clk);
		`CHK(port_oe_n, UART_OE_N)
		apb(0, OFF_BAUD, 0);
		`CHK(q, 32'h1a)
		apb(0, OFF_CONTROL_BUS_PINS, 0);
		`CHK(q, 32'h51032)
		apb(0, 8'h28, 0);
		`CHK(q, 32'hdead)
		$display("reset and map test done");
		apb(1, OFF_BAUD, 5);
		// parity codes none, odd, even, mark and space, each once
		for (int m = 0; m < 5; m++) begin
			apb(1, OFF_LINE, {27'h0, m[1], 3'(m), m[0]});
			foreach (b[i]) begin
				b[i] = 8'(xs());
				apb(1, OFF_DATA, {24'h0, b[i]});
			end
			repeat (40) @(posedge ref_clk);
			`CHK(control_bus_pins[2], 1'b1)
			repeat (900) @(posedge ref_clk);
			foreach (b[i]) begin
				apb(0, OFF_DATA, 0);
				`CHK(q, exp_char(b[i], m[0]))
			end
		end
		$display("loopback test done");
		// rts off loops back as cts off: the byte must wait for rts
		apb(1, OFF_LINE, 32'h40);
		apb(1, OFF_DATA, {24'h0, b[0]});
		repeat (40) @(posedge ref_clk);
		`CHK(control_bus_pins[2], 1'b0)
		apb(1, OFF_MODEM, 1);
		repeat (300) @(posedge ref_clk);
		apb(0, OFF_DATA, 0);
		`CHK(q, {24'h0, b[0]})
		$display("flow control test done");
		apb(1, OFF_LINE, 32'h20);
		repeat (600) @(posedge ref_clk);
		apb(1, OFF_LINE, 0);
		repeat (400) @(posedge ref_clk);
		apb(0, OFF_STATUS, 0);
		`CHK(q[ST_BRK], 1'b1)
		`CHK(q[ST_ERR], 1'b0)
		apb(1, OFF_STATUS, 32'h200);
		apb(0, OFF_STATUS, 0);
		`CHK(q[ST_BRK], 1'b0)
		apb(1, OFF_INVERT, 1);
		repeat (6) @(posedge ref_clk);
		`CHK(port_out[0], 1'b0)
		apb(1, OFF_INVERT, 0);
		apb(1, OFF_USB, 1);
		repeat (4) @(posedge ref_clk);
		`CHK(control_bus_pins[3], 1'b0)
		apb(1, OFF_USB, 3);
		repeat (4) @(posedge ref_clk);
		`CHK(control_bus_pins[3], 1'b1)
		`CHK(control_bus_pins[4], 1'b0)
		$display("break, invert and power test done");
		loop <= 0;
		apb(1, OFF_BITBANG, 32'hff01);
		b[0] = 8'(xs());
		apb(1, OFF_DATA, {24'h0, b[0]});
		repeat (100) @(posedge ref_clk);
		`CHK(port_out, b[0])
		$display("bit-bang test done");
		// mid-run reset empties the fifos, so the sync samples are the only rx bytes
		srst <= 1;
		repeat (2) @(posedge ref_clk);
		srst <= 0;
		apb(0, OFF_BAUD, 0);
		`CHK(q, 32'h1a)
		apb(1, OFF_BITBANG, 32'hff02);
		b[1] = 8'(xs());
		b[2] = 8'(xs());
		apb(1, OFF_DATA, {24'h0, b[1]});
		apb(1, OFF_DATA, {24'h0, b[2]});
		repeat (300) @(posedge ref_clk);
		apb(0, OFF_DATA, 0);
		`CHK(q, 32'hff)
		apb(0, OFF_DATA, 0);
		`CHK(q, {24'h0, b[1]})
		$display("reset and sync bit-bang test done");
		print_verdict();
	end
endmodule
